/* pkg/see_cfg.svh */
`ifndef SEE_CFG_SVH
`define SEE_CFG_SVH

// Word and array geometry
`define SEE_BYTE_BITS 8
`define SEE_ADDR_BITS 11
`define SEE_PAGE_BYTES 16
`define SEE_ACK_SLOT 4'h8
`define SEE_BIT_LAST 4'h9

// System clock
`define SEE_CLK_NS 20
`define SEE_CLK_MHZ 50

// Internal write cycle, longest time, rounded down to cycles
`define SEE_WC_TIME_MS 5
`define SEE_WC_CYC (`SEE_WC_TIME_MS * 1000 * `SEE_CLK_MHZ)

// Serial clock made by the controller, least period, quarters rounded up
`define SEE_SCL_PERIOD_NS 2500
`define SEE_QTR_CYC ((`SEE_SCL_PERIOD_NS / 4 + `SEE_CLK_NS - 1) / `SEE_CLK_NS)

`endif

/* pkg/see_pkg.sv */
package see_pkg;

  typedef enum logic [4:0] {
    SEE_D_IDLE  = 5'h01,
    SEE_D_DEV   = 5'h02,
    SEE_D_ADDR  = 5'h04,
    SEE_D_WDATA = 5'h08,
    SEE_D_RDATA = 5'h10
  } see_dst_t;

  typedef enum logic [3:0] {
    SEE_H_IDLE  = 4'h1,
    SEE_H_START = 4'h2,
    SEE_H_BYTE  = 4'h4,
    SEE_H_STOP  = 4'h8
  } see_hst_t;

  typedef enum logic [1:0] {
    SEE_OP_START = 2'h0,
    SEE_OP_WRITE = 2'h1,
    SEE_OP_READ  = 2'h2,
    SEE_OP_STOP  = 2'h3
  } see_op_t;

endpackage

/* pkg/see_if.sv */
`timescale 1ns/1ns
interface see_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_s_o;
  logic sda_s_oe_n;
  logic sda;

  // Open-drain wire with pull-up
  assign sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);

  modport ctl(
    output scl,
    output sda_m_o,
    output sda_m_oe_n,
    input sda
  );

  modport dev(
    input scl,
    input sda,
    output sda_s_o,
    output sda_s_oe_n
  );
endinterface

/* rtl/see_mem.sv */
// Function
// RQ1: Sample on clock rise, change after fall
// RQ2: Data changes only while clock low
// RQ3: Data fall with clock high starts
// RQ4: Data rise with clock high stops
// RQ5: Stop after write data starts internal write
// RQ6: Eight-bit words, ninth clock acknowledges
// RQ7: Read continues on acknowledge, ends on stop
// RQ8: No acknowledge without stop: stay released
// RQ9: Address word: type, three bits, direction
// RQ10: Three bits are upper address bits
// RQ11: Direction low writes, high reads
// RQ12: Wrong type code: standby, no acknowledge
// RQ13: Acknowledge all bytes; ignore bus while writing
// RQ14: Further data bytes form page write
// RQ15: Only page offset bits increment, wrapping
// RQ16: Protected: refuse first data byte, write nothing
// RQ17: Protection covers array; reads always work
// RQ18: Unconnected protect input reads as low
// RQ19: Busy: no acknowledge to polling address
// RQ20: Pull data low or release only
// RQ21: Internal write lasts at most five milliseconds
// RQ22: Start mid-transaction restarts address decoding
// RQ23: Stop before any data byte: no write
`timescale 1ns/1ns
`include "see_cfg.svh"

module see_mem #(
  parameter int WC_CYC = `SEE_WC_CYC,
  // Type code value is arbitrary
  parameter logic [3:0] TYPE_CODE = 4'h5
) (
  input wire logic clock,
  input wire logic srst,
  see_if.dev bus,
  input wire logic wp = 1'b0 // RQ18
);

  localparam int DEPTH = 1 << `SEE_ADDR_BITS;
  localparam int WCW = $clog2(WC_CYC + 1);

  logic [`SEE_BYTE_BITS-1:0] mem [DEPTH];
  logic [`SEE_BYTE_BITS-1:0] pbuf [`SEE_PAGE_BYTES];

  logic [1:0] scl_sy_r;
  logic [1:0] sda_sy_r;
  logic [1:0] wp_sy_r;
  logic scl_d_r;
  logic sda_d_r;
  see_pkg::see_dst_t st_r;
  logic [3:0] cnt_r;
  logic [7:0] shr_r;
  logic [`SEE_ADDR_BITS-1:0] addr_r;
  logic [7:0] rd_byte_r;
  logic sdal_r;
  logic dack_r;
  logic mack_r;
  logic [`SEE_PAGE_BYTES-1:0] pval_r;
  logic busy_r;
  logic cp_run_r;
  logic [3:0] cp_r;
  logic [WCW-1:0] wc_r;

  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic start_w;
  logic stop_w;
  logic rise_w;
  logic fall_w;
  logic byte_w;
  logic ackend_w;
  logic dev_hit;
  logic wr_ok;

  function automatic logic [`SEE_ADDR_BITS-1:0] next_addr(
    input logic [`SEE_ADDR_BITS-1:0] a
  );
    next_addr = a + `SEE_ADDR_BITS'(1);
  endfunction

  // Pins pass two flops; only the second is read
  always_ff @(posedge clock) begin
    if (srst) begin
      scl_sy_r <= 2'h3;
      sda_sy_r <= 2'h3;
      wp_sy_r <= 2'h0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_sy_r <= {scl_sy_r[0], bus.scl};
      sda_sy_r <= {sda_sy_r[0], bus.sda};
      wp_sy_r <= {wp_sy_r[0], wp};
      scl_d_r <= scl_sy_r[1];
      sda_d_r <= sda_sy_r[1];
    end
  end

  assign scl_s = scl_sy_r[1];
  assign sda_s = sda_sy_r[1];
  assign wp_s = wp_sy_r[1];
  assign start_w = scl_s && scl_d_r && sda_d_r && !sda_s; // RQ3
  assign stop_w = scl_s && scl_d_r && !sda_d_r && sda_s; // RQ4
  assign rise_w = scl_s && !scl_d_r;
  assign fall_w = !scl_s && scl_d_r;
  assign byte_w = fall_w && cnt_r == `SEE_ACK_SLOT; // RQ6
  assign ackend_w = fall_w && cnt_r == `SEE_BIT_LAST;
  assign dev_hit = shr_r[7:4] == TYPE_CODE && !busy_r; // RQ12 RQ19
  assign wr_ok = st_r == see_pkg::SEE_D_WDATA && !wp_s; // RQ16 RQ17

  // Bit counter and shift register; bits taken on the rise
  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_r <= 4'h0;
      shr_r <= 8'h00;
    end else if (start_w) begin
      cnt_r <= 4'h0; // RQ22
    end else if (rise_w) begin
      if (cnt_r < `SEE_ACK_SLOT) begin
        shr_r <= {shr_r[6:0], sda_s}; // RQ1 RQ9
      end
      if (cnt_r != `SEE_BIT_LAST) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end else if (ackend_w) begin
      cnt_r <= 4'h0;
    end
  end

  // Transaction sequencer and data line drive, changed after a fall or on a start or stop
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= see_pkg::SEE_D_IDLE;
      sdal_r <= 1'b0;
      dack_r <= 1'b0;
    end else if (start_w) begin
      st_r <= see_pkg::SEE_D_DEV; // RQ22
      sdal_r <= 1'b0;
      dack_r <= 1'b0;
    end else if (stop_w) begin
      st_r <= see_pkg::SEE_D_IDLE; // RQ4 RQ7
      sdal_r <= 1'b0;
    end else if (byte_w) begin
      case (st_r)
        see_pkg::SEE_D_DEV: begin
          if (dev_hit) begin
            sdal_r <= 1'b1;
            if (shr_r[0]) begin
              st_r <= see_pkg::SEE_D_RDATA; // RQ11
              dack_r <= 1'b1;
            end else begin
              st_r <= see_pkg::SEE_D_ADDR; // RQ11
            end
          end else begin
            st_r <= see_pkg::SEE_D_IDLE; // RQ12 RQ19
          end
        end
        see_pkg::SEE_D_ADDR: begin
          sdal_r <= 1'b1; // RQ13
          st_r <= see_pkg::SEE_D_WDATA;
        end
        see_pkg::SEE_D_WDATA: begin
          if (wp_s) begin
            st_r <= see_pkg::SEE_D_IDLE; // RQ16
          end else begin
            sdal_r <= 1'b1; // RQ13 RQ14
          end
        end
        default: begin
          sdal_r <= 1'b0; // RQ7
        end
      endcase
    end else if (ackend_w) begin
      dack_r <= 1'b0;
      if (st_r == see_pkg::SEE_D_RDATA) begin
        if (dack_r) begin
          sdal_r <= ~rd_byte_r[7]; // RQ1 RQ2
        end else if (mack_r) begin
          sdal_r <= ~mem[next_addr(addr_r)][7]; // RQ7
        end else begin
          sdal_r <= 1'b0; // RQ8
          st_r <= see_pkg::SEE_D_IDLE;
        end
      end else begin
        sdal_r <= 1'b0; // RQ6
      end
    end else if (fall_w && st_r == see_pkg::SEE_D_RDATA && cnt_r != 4'h0) begin
      sdal_r <= ~rd_byte_r[3'(4'h7 - cnt_r)]; // RQ1 RQ2
    end
  end

  // Address pointer, read byte and the controller's read acknowledge
  always_ff @(posedge clock) begin
    if (srst) begin
      addr_r <= '0;
      rd_byte_r <= 8'hFF;
      mack_r <= 1'b0;
    end else if (byte_w && st_r == see_pkg::SEE_D_DEV && dev_hit) begin
      addr_r[10:8] <= shr_r[3:1]; // RQ10
      rd_byte_r <= mem[{shr_r[3:1], addr_r[7:0]}];
    end else if (byte_w && st_r == see_pkg::SEE_D_ADDR) begin
      addr_r[7:0] <= shr_r; // RQ13
    end else if (byte_w && wr_ok) begin
      addr_r[3:0] <= addr_r[3:0] + 4'h1; // RQ15
    end else if (rise_w && cnt_r == `SEE_ACK_SLOT && st_r == see_pkg::SEE_D_RDATA && !dack_r) begin
      mack_r <= !sda_s; // RQ7
    end else if (ackend_w && st_r == see_pkg::SEE_D_RDATA && !dack_r && mack_r) begin
      addr_r <= next_addr(addr_r); // RQ7
      rd_byte_r <= mem[next_addr(addr_r)];
    end
  end

  // Page buffer; a later byte at the same offset overwrites the earlier one
  always_ff @(posedge clock) begin
    if (srst) begin
      pval_r <= '0;
    end else if (byte_w && st_r == see_pkg::SEE_D_ADDR) begin
      pval_r <= '0;
    end else if (byte_w && wr_ok) begin
      pval_r[addr_r[3:0]] <= 1'b1; // RQ14 RQ15
    end
  end

  always_ff @(posedge clock) begin
    if (byte_w && wr_ok) begin
      pbuf[addr_r[3:0]] <= shr_r; // RQ15
    end
  end

  // Self-timed write; the bus is ignored meanwhile except for a refused poll
  always_ff @(posedge clock) begin
    if (srst) begin
      busy_r <= 1'b0;
      cp_run_r <= 1'b0;
      cp_r <= 4'h0;
      wc_r <= '0;
    end else if (stop_w && st_r == see_pkg::SEE_D_WDATA && |pval_r) begin
      busy_r <= 1'b1; // RQ5 RQ13 RQ23
      cp_run_r <= 1'b1;
      cp_r <= 4'h0;
      wc_r <= WCW'(WC_CYC - 1); // RQ21
    end else if (busy_r) begin
      if (cp_r == 4'hF) begin
        cp_run_r <= 1'b0;
      end
      cp_r <= cp_r + 4'h1;
      if (wc_r == '0) begin
        busy_r <= 1'b0; // RQ5 RQ19
      end else begin
        wc_r <= wc_r - WCW'(1);
      end
    end
  end

  // One page slot committed per cycle, only slots that were loaded
  always_ff @(posedge clock) begin
    if (busy_r && cp_run_r && pval_r[cp_r]) begin
      mem[{addr_r[10:4], cp_r}] <= pbuf[cp_r]; // RQ14
    end
  end

  assign bus.sda_s_o = 1'b0; // RQ20
  assign bus.sda_s_oe_n = ~sdal_r; // RQ20

endmodule // see_mem

/* rtl/see_ctl.sv */
`timescale 1ns/1ns
`include "see_cfg.svh"

module see_fifo #(
  parameter int W = 11,
  parameter int D = 4
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] n_r;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(D - 1)) ? '0 : p + AW'(1);
  endfunction

  assign in_ready = n_r != (AW + 1)'(D);
  assign out_valid = n_r != '0;
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wp_r <= '0;
      rp_r <= '0;
      n_r <= '0;
    end else begin
      if (push) begin
        wp_r <= ptr_inc(wp_r);
      end
      if (pop) begin
        rp_r <= ptr_inc(rp_r);
      end
      if (push && !pop) begin
        n_r <= n_r + (AW + 1)'(1);
      end else if (pop && !push) begin
        n_r <= n_r - (AW + 1)'(1);
      end
    end
  end

endmodule // see_fifo

module see_ctl #(
  parameter int QTR_CYC = `SEE_QTR_CYC,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clock,
  input wire logic srst,
  see_if.ctl bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire see_pkg::see_op_t cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_nack,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);

  localparam int QW = $clog2(QTR_CYC + 1);

  logic f_valid;
  logic f_ready;
  logic [10:0] f_data;
  logic [1:0] sda_sy_r;
  see_pkg::see_hst_t st_r;
  see_pkg::see_op_t op_r;
  logic [1:0] q_r;
  logic [QW-1:0] tq_r;
  logic [3:0] bit_r;
  logic [8:0] tx_r;
  logic [8:0] rx_r;
  logic scl_r;
  logic sdal_r;
  logic rsp_valid_r;
  logic [7:0] rsp_data_r;
  logic rsp_nack_r;
  logic tick;
  logic [8:0] rx_nxt;
  logic [1:0] pat_nxt;
  see_pkg::see_op_t f_op;

  // Line pattern {scl, pull low} for a quarter of a bit time
  function automatic logic [1:0] pat(
    input see_pkg::see_op_t op,
    input logic [1:0] q,
    input logic txb,
    input logic cur
  );
    // Data never moves on the edge that lowers the clock: a race there fakes a start or stop
    case (op)
      see_pkg::SEE_OP_START: pat = (q == 2'h0) ? {1'b0, cur} : (q == 2'h1) ? 2'h0 :
                                   (q == 2'h2) ? 2'h2 : 2'h3; // RQ2 RQ3
      see_pkg::SEE_OP_STOP: pat = (q == 2'h0) ? {1'b0, cur} : (q == 2'h1) ? 2'h1 :
                                  (q == 2'h2) ? 2'h3 : 2'h2; // RQ2 RQ4
      default: pat = (q == 2'h0) ? {1'b0, cur} : {q[1], ~txb}; // RQ2 RQ6
    endcase
  endfunction

  // Commands queue here while a transfer is on the wire
  see_fifo #(.W(11), .D(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .srst(srst),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data({cmd_op, cmd_data, cmd_nack}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  always_ff @(posedge clock) begin
    if (srst) begin
      sda_sy_r <= 2'h3;
    end else begin
      sda_sy_r <= {sda_sy_r[0], bus.sda};
    end
  end

  assign f_ready = st_r == see_pkg::SEE_H_IDLE;
  assign f_op = see_pkg::see_op_t'(f_data[10:9]);
  assign tick = tq_r == '0;
  assign rx_nxt = {rx_r[7:0], sda_sy_r[1]};
  assign pat_nxt = pat(op_r, q_r + 2'h1, tx_r[8], sdal_r);

  // Quarter sequencer; data moves in the second low quarter, and for start and stop also in the last high quarter
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= see_pkg::SEE_H_IDLE;
      op_r <= see_pkg::SEE_OP_STOP;
      q_r <= 2'h0;
      tq_r <= '0;
      bit_r <= 4'h0;
      tx_r <= 9'h1FF;
      rx_r <= 9'h000;
      scl_r <= 1'b1;
      sdal_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 8'h00;
      rsp_nack_r <= 1'b0;
    end else begin
      rsp_valid_r <= 1'b0;
      if (st_r == see_pkg::SEE_H_IDLE) begin
        if (f_valid) begin
          op_r <= f_op;
          q_r <= 2'h0;
          tq_r <= QW'(QTR_CYC - 1);
          bit_r <= 4'h0;
          tx_r <= (f_op == see_pkg::SEE_OP_WRITE) ? {f_data[8:1], 1'b1} : {8'hFF, f_data[0]};
          {scl_r, sdal_r} <= pat(f_op, 2'h0, 1'b1, sdal_r);
          case (f_op)
            see_pkg::SEE_OP_START: st_r <= see_pkg::SEE_H_START;
            see_pkg::SEE_OP_STOP: st_r <= see_pkg::SEE_H_STOP;
            default: st_r <= see_pkg::SEE_H_BYTE;
          endcase
        end
      end else if (!tick) begin
        tq_r <= tq_r - QW'(1);
      end else begin
        tq_r <= QW'(QTR_CYC - 1);
        q_r <= q_r + 2'h1;
        if (q_r != 2'h3) begin
          {scl_r, sdal_r} <= pat_nxt;
        end else if (st_r == see_pkg::SEE_H_BYTE && bit_r != 4'h8) begin
          rx_r <= rx_nxt;
          tx_r <= {tx_r[7:0], 1'b1};
          bit_r <= bit_r + 4'h1;
          {scl_r, sdal_r} <= {1'b0, sdal_r};
        end else begin
          // Clock is left where the op ended; the next op brings it low
          st_r <= see_pkg::SEE_H_IDLE;
          rsp_valid_r <= 1'b1;
          rsp_data_r <= (st_r == see_pkg::SEE_H_BYTE) ? rx_nxt[8:1] : 8'h00;
          rsp_nack_r <= (st_r == see_pkg::SEE_H_BYTE) ? rx_nxt[0] : 1'b0;
        end
      end
    end
  end

  assign bus.scl = scl_r;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe_n = ~sdal_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign rsp_nack = rsp_nack_r;

endmodule // see_ctl

/* test/see_chk.sv */
`timescale 1ns/1ns
module see_chk #(
  parameter logic [3:0] TYPE_CODE = 4'h5
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic scl,
  input wire logic sda_m_o,
  input wire logic sda_m_oe_n,
  input wire logic sda_s_o,
  input wire logic sda_s_oe_n,
  input wire logic sda
);
  logic scl_p_r;
  logic sda_p_r;
  logic [4:0] bit_r;
  logic [7:0] dev_r;
  logic bad_r;
  logic start_w;
  logic rise_w;

  assign start_w = scl && scl_p_r && sda_p_r && !sda;
  assign rise_w = scl && !scl_p_r;

  always_ff @(posedge clock) begin
    scl_p_r <= scl;
    sda_p_r <= sda;
  end

  // Rises since the last start; saturates so long reads cannot wrap it
  always_ff @(posedge clock) begin
    if (srst) begin
      bit_r <= 5'h1F; // Parked until a first start, so its setup edges count nothing
    end else if (start_w) begin
      bit_r <= 5'h00;
    end else if (rise_w && bit_r != 5'h1F) begin
      bit_r <= bit_r + 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rise_w && bit_r < 5'h08) begin
      dev_r <= {dev_r[6:0], sda};
    end
  end

  always_ff @(posedge clock) begin
    if (srst || start_w) begin
      bad_r <= 1'b0;
    end else if (bit_r == 5'h08 && dev_r[7:4] != TYPE_CODE) begin
      bad_r <= 1'b1;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  property p_pull_only;
    !sda_s_oe_n |-> !sda_s_o;
  endproperty
  a_pull_only: assert property (p_pull_only) else $error("memory drives high");

  property p_ctl_pull_only;
    !sda_m_oe_n |-> !sda_m_o;
  endproperty
  a_ctl_pull_only: assert property (p_ctl_pull_only) else $error("controller drives high");

  property p_dev_chg_low;
    $changed(sda_s_oe_n) |-> !scl;
  endproperty
  a_dev_chg_low: assert property (p_dev_chg_low) else $error("memory moved data in high");

  property p_dev_hold;
    $rose(scl) |-> $stable(sda_s_oe_n) [*6];
  endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("memory data moved after rise");

  property p_ctl_hold;
    scl && bit_r >= 5'h01 && bit_r <= 5'h08 |-> $stable(sda_m_oe_n);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold) else $error("controller data moved in high");

  property p_quiet;
    bit_r < 5'h08 |-> sda_s_oe_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("memory drove in address word");

  property p_bad;
    bad_r |-> sda_s_oe_n;
  endproperty
  a_bad: assert property (p_bad) else $error("memory answered foreign code");

  property p_ack_rel;
    $fell(scl) && bit_r == 5'h09 && !dev_r[0] |-> ##[1:6] sda_s_oe_n;
  endproperty
  a_ack_rel: assert property (p_ack_rel) else $error("ack not released");

  property p_scl_hi;
    $rose(scl) |-> scl [*6];
  endproperty
  a_scl_hi: assert property (p_scl_hi) else $error("clock high too short");

  property p_scl_lo;
    $fell(scl) |-> !scl [*3];
  endproperty
  a_scl_lo: assert property (p_scl_lo) else $error("clock low too short");
endmodule // see_chk

/* test/tb_serial_eeprom_bus_write_logic.sv */
`timescale 1ns/1ns
module tb_serial_eeprom_bus_write_logic;
  // Type code value is arbitrary
  localparam logic [3:0] TC = 4'h5;
  localparam see_pkg::see_op_t op_st = see_pkg::SEE_OP_START;
  localparam see_pkg::see_op_t op_wr = see_pkg::SEE_OP_WRITE;
  localparam see_pkg::see_op_t op_rd = see_pkg::SEE_OP_READ;
  localparam see_pkg::see_op_t op_sp = see_pkg::SEE_OP_STOP;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  see_pkg::see_op_t cmd_op = op_sp;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_nack = 1'b0;
  logic wp = 1'b0;
  logic cmd_ready;
  logic rsp_valid;
  logic rsp_nack;
  logic [7:0] rsp_data;
  int err_total = 0;
  int comparisons = 0;
  int seed = 11;
  logic saw_full = 1'b0;
  logic [8:0] junk;
  logic [8:0] rq[$];
  logic [7:0] model[0:2047];

  see_if see_if_i();
  see_ctl #(.QTR_CYC(4), .FIFO_DEPTH(4)) see_ctl_i(.clock(clock), .srst(srst),
    .bus(see_if_i.ctl), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .cmd_nack(cmd_nack), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_nack(rsp_nack));
  see_mem #(.WC_CYC(200), .TYPE_CODE(TC)) see_mem_i(.clock(clock), .srst(srst),
    .bus(see_if_i.dev), .wp(wp));
  see_chk #(.TYPE_CODE(TC)) see_chk_i(.clock(clock), .srst(srst), .scl(see_if_i.scl),
    .sda_m_o(see_if_i.sda_m_o), .sda_m_oe_n(see_if_i.sda_m_oe_n), .sda_s_o(see_if_i.sda_s_o),
    .sda_s_oe_n(see_if_i.sda_s_oe_n), .sda(see_if_i.sda));

  initial begin
    forever #10 clock = ~clock;
  end

  always @(posedge clock) begin
    if (rsp_valid === 1'b1) rq.push_back({rsp_nack, rsp_data});
  end

  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic stall();
    err_total++;
    $display("ERROR wait expected done seen timeout");
    close_out();
  endtask

  task automatic chk_ack(string what, logic exp, logic got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] devw(logic [10:0] a, logic rd);
    return {TC, a[10:8], rd};
  endfunction

  // Leaves valid high so back-to-back pushes never drop it in between
  task automatic push(see_pkg::see_op_t o, logic [7:0] d, logic n);
    int k;
    k = 0;
    cmd_valid = 1'b1;
    cmd_op = o;
    cmd_data = d;
    cmd_nack = n;
    do begin
      @(posedge clock);
      k++;
      if (cmd_ready === 1'b0) saw_full = 1'b1;
    end while (cmd_ready !== 1'b1 && k < 2000);
    if (cmd_ready !== 1'b1) stall();
    #1;
  endtask

  task automatic pull(output logic [8:0] r);
    int k;
    k = 0;
    while (rq.size() == 0 && k < 6000) begin
      @(posedge clock);
      k++;
    end
    if (rq.size() == 0) stall();
    r = rq.pop_front();
    #1;
  endtask

  task automatic op(see_pkg::see_op_t o, logic [7:0] d, logic n, output logic [8:0] r);
    push(o, d, n);
    cmd_valid = 1'b0;
    pull(r);
  endtask

  task automatic st();
    op(op_st, 8'h00, 1'b0, junk);
  endtask

  task automatic sp();
    op(op_sp, 8'h00, 1'b0, junk);
  endtask

  task automatic wrb(logic [7:0] d, logic e);
    op(op_wr, d, 1'b0, junk);
    chk_ack("write ack", e, junk[8]);
  endtask

  task automatic hdr(logic [10:0] a);
    st();
    wrb(devw(a, 1'b0), 1'b0);
    wrb(a[7:0], 1'b0);
  endtask

  // Mode 0 idle expected, 1 busy expected, 2 either
  task automatic settle(logic [1:0] mode);
    logic a;
    int k;
    k = 0;
    do begin
      st();
      op(op_wr, devw(11'h000, 1'b0), 1'b0, junk);
      a = junk[8];
      sp();
      if (k == 0 && mode < 2'h2) chk_ack("first poll", mode[0], a);
      k++;
    end while (a && k < 6);
    chk_ack("poll done", 1'b0, a);
  endtask

  task automatic rd(logic [10:0] a, int n);
    hdr(a);
    st();
    wrb(devw(a, 1'b1), 1'b0);
    for (int i = 0; i < n; i++) begin
      op(op_rd, 8'h00, i == n - 1, junk);
      chk_byte("read data", model[a + 11'(i)], junk[7:0]);
    end
    op(op_rd, 8'h00, 1'b1, junk);
    chk_byte("released line", 8'hFF, junk[7:0]);
    sp();
  endtask

  initial begin
    logic [10:0] a;
    logic [7:0] d;
    repeat (4) @(posedge clock);
    #1;
    srst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      a = 11'($random(seed));
      d = 8'($random(seed));
      hdr(a);
      wrb(d, 1'b0);
      model[a] = d;
      sp();
      settle(2'h1);
      rd(a, 1);
    end
    // Page starts at offset 13 so the burst wraps; guard byte sits just past it
    a = {7'($random(seed)), 4'hD};
    hdr(a + 11'h003);
    wrb(8'h5A, 1'b0);
    model[a + 11'h003] = 8'h5A;
    sp();
    settle(2'h1);
    push(op_st, 8'h00, 1'b0);
    push(op_wr, devw(a, 1'b0), 1'b0);
    push(op_wr, a[7:0], 1'b0);
    for (int i = 0; i < 19; i++) begin
      d = 8'($random(seed));
      push(op_wr, d, 1'b0);
      model[{a[10:4], a[3:0] + 4'(i)}] = d;
    end
    push(op_sp, 8'h00, 1'b0);
    cmd_valid = 1'b0;
    for (int i = 0; i < 23; i++) begin
      pull(junk);
      if (i > 0 && i < 22) chk_ack("page ack", 1'b0, junk[8]);
    end
    chk_ack("queue full", 1'b1, saw_full);
    settle(2'h1);
    rd({a[10:4], 4'h0}, 17);
    st();
    wrb({~TC, 4'h0}, 1'b1);
    sp();
    // Protect input goes through a two-stage sync, so set it well ahead
    wp = 1'b1;
    hdr(a);
    wrb(~model[a], 1'b1);
    sp();
    settle(2'h2);
    rd(a, 1);
    wp = 1'b0;
    hdr(a);
    sp();
    settle(2'h0);
    close_out();
  end
endmodule // tb_serial_eeprom_bus_write_logic
